// ### dcc_pkg.sv
package dcc_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] DCC_OFS_CTRL   = 8'h9C; // Comparator control
    localparam logic [7:0] DCC_OFS_STATUS = 8'hA0; // Sticky event status
    localparam logic [7:0] DCC_OFS_MASK   = 8'hA4; // Interrupt mask
    // ------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------
    localparam int DCC_B_C2RES = 7;  // Comparator two result
    localparam int DCC_B_C1RES = 6;  // Comparator one result
    localparam int DCC_B_CMP2_INVERT = 5;  // Comparator two invert
    localparam int DCC_B_CMP1_INVERT = 4;  // Comparator one invert
    localparam int DCC_B_ISW   = 3;  // Input switch
    localparam int DCC_B_CHG   = 0;  // Status: change event
    // ------------------------------------------------------------
    // Reset values and modes
    // ------------------------------------------------------------
    localparam logic [4:0] DCC_CTRL_RST = 5'h07;   // Reset of bits 4..0; writable bits are 5..0
    typedef enum logic [2:0] {
        DCC_M_RESET  = 3'h0, // Both on, inputs as reset
        DCC_M_ONE    = 3'h1, // One with switchable minus input
        DCC_M_VREF   = 3'h2, // Both against internal reference
        DCC_M_FOUR   = 3'h3, // Two independent comparators
        DCC_M_COMMON = 3'h4, // Common reference
        DCC_M_CMOUT  = 3'h5, // Common reference, outputs on pins
        DCC_M_INDOUT = 3'h6, // Common pin2 reference, outputs on pins
        DCC_M_OFF    = 3'h7  // Comparators off
    } dcc_mode_t;
endpackage

// ### dcc_top.sv
// Behaviour
// - Comparator high when plus above minus
// - Bit 7 shows comparator two result
// - Bit 6 shows comparator one result
// - Bit 5 inverts comparator two
// - Bit 4 inverts comparator one
// - Mode 001 switch picks pin3 or pin0
// - Mode 010 switch picks pins 3,2 or 0,1
// - Low three bits choose eight configurations
// - Mode 010 puts reference on plus inputs
// - Inputs on pins 0-3, outputs pins 3-4
// - Flag set on change from latched value
// - Control access latches outputs, ends mismatch
// - Reset gives mode 111, comparators off
//
// Register access over Wishbone was chosen for this implementation.
module dcc_top
    import dcc_pkg::*;
(
    input  wire logic        clk_i,         // 100 MHz clock
    input  wire logic        rst_i,         // Sync reset, high
    input  wire logic [7:0]  wb_adr_i,      // Byte address
    input  wire logic [31:0] wb_dat_i,      // Write data
    output logic      [31:0] wb_dat_o,      // Read data
    input  wire logic        wb_we_i,       // Write enable
    input  wire logic [3:0]  wb_sel_i,      // Byte selects
    input  wire logic        wb_cyc_i,      // Cycle
    input  wire logic        wb_stb_i,      // Strobe
    output logic             wb_ack_o,      // Acknowledge
    input  wire logic        cmp1_raw_i,    // Comparator one core output
    input  wire logic        cmp2_raw_i,    // Comparator two core output
    output logic [2:0]       cmp1_minus_sel_o, // Minus input pin index
    output logic [2:0]       cmp2_minus_sel_o, // Minus select pin
    output logic [2:0]       cmp1_plus_sel_o,  // Plus select pin
    output logic [2:0]       cmp2_plus_sel_o,  // Plus select pin
    output logic             vref_to_plus_o,   // Reference onto plus inputs
    output logic             cmp1_en_o,     // Comparator one powered
    output logic             cmp2_en_o,     // Comparator two powered
    output logic             pin3_out_en_o, // Comparator one drives pin 3
    output logic             pin4_out_en_o, // Comparator two drives pin 4
    output logic             cmp1_pin_o,    // Value for pin 3
    output logic             cmp2_pin_o,    // Value for pin 4
    output logic             irq_o          // Level interrupt
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [1:0] sync1_reg;   // First synchroniser stage
    logic [1:0] sync2_reg;   // Second synchroniser stage
    logic       cmp2_invert_reg;   // Comparator two invert
    logic       cmp1_invert_reg;   // Comparator one invert
    logic       isw_reg;     // Input switch
    dcc_mode_t  mode_reg;    // Configuration select
    logic [1:0] latch_reg;   // Outputs latched at last access
    logic       flag_reg;    // Sticky change flag
    logic       mask_reg;    // Interrupt enable
    logic [1:0] res;         // Polarity-corrected results
    logic       acc;         // Bus access this cycle
    logic       ctrl_hit;    // Control register hit
    logic       wr;          // Write strobe
    logic       mismatch;    // Live result differs from latch
    logic [7:0] ctrl_rd;     // Control read value

    assign acc      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr       = acc & wb_we_i & wb_sel_i[0];
    assign ctrl_hit = acc & (wb_adr_i == DCC_OFS_CTRL);

    // ------------------------------------------------------------
    // Result path
    // ------------------------------------------------------------
    // Raw outputs are async to clk; only stage two is read
    // Stage one may go metastable, so it feeds nothing but stage two.
    // The price is two edges of latency between a core changing and
    // the status bits or the change detector seeing it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_reg <= 2'h0;
            sync2_reg <= 2'h0;
        end else begin
            sync1_reg <= {cmp2_raw_i, cmp1_raw_i};
            sync2_reg <= sync1_reg;
        end
    end

    // Off comparators read zero; inversion applied after sync
    // Forcing zero for an unpowered core keeps a floating output from
    // raising a change event while the module is parked off.
    always_comb begin
        res[0] = (mode_reg != DCC_M_OFF) & (sync2_reg[0] ^ cmp1_invert_reg);
        res[1] = (mode_reg != DCC_M_OFF) & (mode_reg != DCC_M_ONE)
               & (sync2_reg[1] ^ cmp2_invert_reg);
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    // Writable bits; top two are read only
    // Bits 7 and 6 are rebuilt from the live results on every read,
    // so a write to them has nowhere to land and is dropped.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {cmp2_invert_reg, cmp1_invert_reg, isw_reg} <= 3'h0;
            mode_reg <= DCC_M_OFF;
        end else if (ctrl_hit & wr) begin
            cmp2_invert_reg <= wb_dat_i[DCC_B_CMP2_INVERT];
            cmp1_invert_reg <= wb_dat_i[DCC_B_CMP1_INVERT];
            isw_reg   <= wb_dat_i[DCC_B_ISW];
            mode_reg  <= dcc_mode_t'(wb_dat_i[2:0]);
        end
    end

    assign ctrl_rd = {res[1], res[0], cmp2_invert_reg, cmp1_invert_reg, isw_reg, mode_reg};

    // ------------------------------------------------------------
    // Change detection and interrupt
    // ------------------------------------------------------------
    // Any control access refreshes the latch, ending the mismatch
    // Software keeps its own copy of the result bits; the latch mirrors
    // the value it last saw, so a change is judged against that and not
    // against the previous clock. Reading the control register is enough
    // to make the two agree again.
    always_ff @(posedge clk_i) begin
        if (rst_i)
            latch_reg <= 2'h0;
        else if (ctrl_hit)
            latch_reg <= res;
    end

    // Software is expected to mask around mode changes
    // A mode write reroutes the inputs and the cores need time to settle,
    // so a spurious mismatch right after it is expected, not a fault.
    assign mismatch = (res != latch_reg);

    // Set wins over write-one-to-clear
    // A change in the access cycle itself is ignored, since that access
    // latches the very value that would have differed. Outside it, an
    // event that lands with a clear keeps the flag, so none is lost.
    always_ff @(posedge clk_i) begin
        if (rst_i)
            flag_reg <= 1'b0;
        else if (mismatch & ~ctrl_hit)
            flag_reg <= 1'b1;
        else if (wr & (wb_adr_i == DCC_OFS_STATUS) & wb_dat_i[DCC_B_CHG])
            flag_reg <= 1'b0;
    end

    // Mask gates only the interrupt pin; the flag still records events
    // while masked, so polling software sees them too.
    always_ff @(posedge clk_i) begin
        if (rst_i)
            mask_reg <= 1'b0;
        else if (wr & (wb_adr_i == DCC_OFS_MASK))
            mask_reg <= wb_dat_i[DCC_B_CHG];
    end

    // Level output: stays high until the flag is cleared or masked
    assign irq_o = flag_reg & mask_reg;

    // ------------------------------------------------------------
    // Bus slave: one wait-free ack, unmapped reads zero
    // ------------------------------------------------------------
    // A request is taken on the edge where cyc and stb are high and ack
    // is low; ack and read data follow one edge later and stand for one
    // cycle. Gating with ack stops a held strobe from being taken twice,
    // so the master must leave one idle cycle between transfers.
    // Only byte lane zero carries writable bits, so sel[0] alone gates
    // writes; other lanes read back as zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= acc;
            if (acc) begin
                unique case (wb_adr_i)
                    DCC_OFS_CTRL:   wb_dat_o <= {24'h0, ctrl_rd};
                    DCC_OFS_STATUS: wb_dat_o <= {31'h0, flag_reg};
                    DCC_OFS_MASK:   wb_dat_o <= {31'h0, mask_reg};
                    default:        wb_dat_o <= 32'h0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Multiplexer steering
    // ------------------------------------------------------------
    // Selects name the port-A pin index; 3'h7 means unconnected
    // Mode  minus1  plus1  minus2  plus2  note
    // 000   pin0    pin3   pin1    pin2   both on, reset routing
    // 001   0/3     pin2   -       -      comparator two off
    // 010   0/3     ref    1/2     ref    reference on both plus inputs
    // 011   pin0    pin3   pin1    pin2   two independent comparators
    // 100   pin0    pin2   pin1    pin2   pin2 is the common reference
    // 101   as 100, outputs also drive pins 3 and 4
    // 110   pin0    pin2   pin1    pin2   outputs drive pins 3 and 4
    // 111   -       -      -       -      both cores powered down
    always_comb begin
        cmp1_minus_sel_o = 3'h7;
        cmp2_minus_sel_o = 3'h7;
        cmp1_plus_sel_o  = 3'h7;
        cmp2_plus_sel_o  = 3'h7;
        vref_to_plus_o   = 1'b0;
        cmp1_en_o        = 1'b1;
        cmp2_en_o        = 1'b1;
        pin3_out_en_o    = 1'b0;
        pin4_out_en_o    = 1'b0;
        unique case (mode_reg)
            DCC_M_RESET, DCC_M_FOUR: begin
                cmp1_minus_sel_o = 3'h0;
                cmp1_plus_sel_o  = 3'h3;
                cmp2_minus_sel_o = 3'h1;
                cmp2_plus_sel_o  = 3'h2;
            end
            DCC_M_ONE: begin
                cmp1_minus_sel_o = isw_reg ? 3'h3 : 3'h0;
                cmp1_plus_sel_o  = 3'h2;
                cmp2_en_o        = 1'b0;
            end
            DCC_M_VREF: begin
                cmp1_minus_sel_o = isw_reg ? 3'h3 : 3'h0;
                cmp2_minus_sel_o = isw_reg ? 3'h2 : 3'h1;
                vref_to_plus_o   = 1'b1;
            end
            DCC_M_COMMON, DCC_M_CMOUT: begin
                cmp1_minus_sel_o = 3'h0;
                cmp2_minus_sel_o = 3'h1;
                cmp1_plus_sel_o  = 3'h2;
                cmp2_plus_sel_o  = 3'h2;
                pin3_out_en_o    = (mode_reg == DCC_M_CMOUT);
                pin4_out_en_o    = (mode_reg == DCC_M_CMOUT);
            end
            DCC_M_INDOUT: begin
                cmp1_minus_sel_o = 3'h0;
                cmp2_minus_sel_o = 3'h1;
                cmp2_plus_sel_o  = 3'h2;
                cmp1_plus_sel_o  = 3'h2;
                pin3_out_en_o    = 1'b1;
                pin4_out_en_o    = 1'b1;
            end
            DCC_M_OFF: begin
                cmp1_en_o = 1'b0;
                cmp2_en_o = 1'b0;
            end
        endcase
    end

    // Pins carry the unsynchronised core output, polarity applied
    // These bypass the synchroniser on purpose: the pin follows the core
    // with no clock delay, but may glitch while the core settles.
    assign cmp1_pin_o = cmp1_raw_i ^ cmp1_invert_reg;
    assign cmp2_pin_o = cmp2_raw_i ^ cmp2_invert_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Properties judge the design's own state against the rules; all but
    // reset_mode_a are disabled during reset so that reset values are not judged.
    // Reset and configuration
    reset_mode_a: assert property (@(posedge clk_i) rst_i |=> mode_reg == DCC_M_OFF)
        else $error("mode not off after reset");
    off_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_reg == DCC_M_OFF |-> !cmp1_en_o && !cmp2_en_o
            && !ctrl_rd[DCC_B_C2RES] && !ctrl_rd[DCC_B_C1RES])
        else $error("off mode still active");
    mode_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_hit && wr |=> mode_reg == $past(wb_dat_i[2:0])
            && isw_reg == $past(wb_dat_i[DCC_B_ISW]))
        else $error("mode field not written");
    inv_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_hit && wr |=> cmp2_invert_reg == $past(wb_dat_i[DCC_B_CMP2_INVERT])
            && cmp1_invert_reg == $past(wb_dat_i[DCC_B_CMP1_INVERT]))
        else $error("invert bits not written");
    // Result path
    sync_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(rst_i) == 0 && $past(rst_i, 2) == 0
            |-> sync2_reg == $past({cmp2_raw_i, cmp1_raw_i}, 2))
        else $error("synchroniser delay wrong");
    c2_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_reg == DCC_M_FOUR |-> ctrl_rd[DCC_B_C2RES] == (sync2_reg[1] ^ cmp2_invert_reg))
        else $error("bit 7 mismatch");
    c1_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_reg == DCC_M_FOUR |-> ctrl_rd[DCC_B_C1RES] == (sync2_reg[0] ^ cmp1_invert_reg))
        else $error("bit 6 mismatch");
    single_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_reg == DCC_M_ONE |-> !cmp2_en_o && !ctrl_rd[DCC_B_C2RES])
        else $error("comparator two active in mode 001");
    // Routing
    switch_one_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_reg == DCC_M_ONE |-> cmp1_minus_sel_o == (isw_reg ? 3'h3 : 3'h0))
        else $error("mode 001 routing wrong");
    switch_two_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode_reg == DCC_M_VREF |-> vref_to_plus_o
            && cmp2_minus_sel_o == (isw_reg ? 3'h2 : 3'h1))
        else $error("mode 010 routing wrong");
    vref_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
        vref_to_plus_o |-> mode_reg == DCC_M_VREF)
        else $error("reference outside mode 010");
    out_pins_a: assert property (@(posedge clk_i) disable iff (rst_i)
        pin3_out_en_o || pin4_out_en_o
            |-> mode_reg == DCC_M_CMOUT || mode_reg == DCC_M_INDOUT)
        else $error("output pin driven in wrong mode");
    // Change detection and interrupt
    flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mismatch && !ctrl_hit |=> flag_reg)
        else $error("change flag not set");
    flag_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        flag_reg && !(wr && wb_adr_i == DCC_OFS_STATUS && wb_dat_i[DCC_B_CHG])
            |=> flag_reg)
        else $error("change flag lost");
    flag_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !mismatch && wr && wb_adr_i == DCC_OFS_STATUS && wb_dat_i[DCC_B_CHG]
            |=> !flag_reg)
        else $error("change flag not cleared");
    latch_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_hit |=> latch_reg == $past(res))
        else $error("access did not latch");
    latch_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl_hit |=> $stable(latch_reg))
        else $error("latch moved without access");
    mask_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && wb_adr_i == DCC_OFS_MASK |=> mask_reg == $past(wb_dat_i[DCC_B_CHG]))
        else $error("mask bit not written");
    irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o == (flag_reg && mask_reg))
        else $error("irq level wrong");
    // Bus handshake
    ack_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged");
    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    status_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        acc && wb_adr_i == DCC_OFS_STATUS |=> wb_dat_o == {31'h0, $past(flag_reg)})
        else $error("status read data wrong");
    unmapped_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        acc && wb_adr_i != DCC_OFS_CTRL && wb_adr_i != DCC_OFS_STATUS
            && wb_adr_i != DCC_OFS_MASK |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");

    flag_cov_c:  cover property (@(posedge clk_i) disable iff (rst_i) !flag_reg ##1 flag_reg);
    irq_cov_c:   cover property (@(posedge clk_i) disable iff (rst_i) irq_o ##[1:20] !irq_o);
    vref_cov_c:  cover property (@(posedge clk_i) disable iff (rst_i) mode_reg == DCC_M_VREF && isw_reg);
    pins_cov_c:  cover property (@(posedge clk_i) disable iff (rst_i) pin3_out_en_o && pin4_out_en_o);
    single_cov_c: cover property (@(posedge clk_i) disable iff (rst_i) mode_reg == DCC_M_ONE && isw_reg);
endmodule

// ### dcc_cmp_model.sv
// ------------------------------------------------------------
// Behavioural comparator cores and pin levels
// ------------------------------------------------------------
module dcc_cmp_model (
    input  wire logic [31:0] pin_lvl_i,  // Pin 0..3 levels, pin 0 lowest byte
    input  wire logic [7:0]  vref_lvl_i, // Internal reference level
    input  wire logic [2:0]  c1_plus_i,  // Comparator one plus select
    input  wire logic [2:0]  c1_minus_i, // Comparator one minus select
    input  wire logic [2:0]  c2_plus_i,  // Comparator two plus select
    input  wire logic [2:0]  c2_minus_i, // Comparator two minus select
    input  wire logic        vref_i,     // Reference onto plus inputs
    input  wire logic        c1_en_i,    // Comparator one powered
    input  wire logic        c2_en_i,    // Comparator two powered
    output logic             cmp1_raw_o, // Comparator one core output
    output logic             cmp2_raw_o  // Comparator two core output
);
    timeunit 1ns;
    timeprecision 1ps;
    // Unconnected selects read ground, so a bad route shows as a wrong result
    function automatic logic [7:0] lvl(input logic [2:0] s);
        return (s < 3'h4) ? pin_lvl_i[s[1:0]*8 +: 8] : 8'h00;
    endfunction
    // High when plus above minus; an unpowered core sits low
    assign cmp1_raw_o = c1_en_i & ((vref_i ? vref_lvl_i : lvl(c1_plus_i)) > lvl(c1_minus_i));
    assign cmp2_raw_o = c2_en_i & ((vref_i ? vref_lvl_i : lvl(c2_plus_i)) > lvl(c2_minus_i));
endmodule

// ### testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import dcc_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk_i = 0, rst_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic [3:0]  wb_sel_i = 4'h0;
    logic        wb_ack_o, cmp1_raw_i, cmp2_raw_i, vref_to_plus_o, cmp1_en_o, cmp2_en_o;
    logic        pin3_out_en_o, pin4_out_en_o, cmp1_pin_o, cmp2_pin_o, irq_o;
    logic [2:0]  cmp1_minus_sel_o, cmp2_minus_sel_o, cmp1_plus_sel_o, cmp2_plus_sel_o;
    logic [31:0] pin_lvl = 32'h281E140A; // Pins 3..0 at 40,30,20,10
    logic [7:0]  vref_lvl = 8'h19;       // Reference at 25, between pins
    int miscompares = 0;
    int cmp_count = 0;
    dcc_top u_dcc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .cmp1_raw_i(cmp1_raw_i),
        .cmp2_raw_i(cmp2_raw_i), .cmp1_minus_sel_o(cmp1_minus_sel_o),
        .cmp2_minus_sel_o(cmp2_minus_sel_o), .cmp1_plus_sel_o(cmp1_plus_sel_o),
        .cmp2_plus_sel_o(cmp2_plus_sel_o), .vref_to_plus_o(vref_to_plus_o),
        .cmp1_en_o(cmp1_en_o), .cmp2_en_o(cmp2_en_o), .pin3_out_en_o(pin3_out_en_o),
        .pin4_out_en_o(pin4_out_en_o), .cmp1_pin_o(cmp1_pin_o), .cmp2_pin_o(cmp2_pin_o),
        .irq_o(irq_o));
    dcc_cmp_model u_dcc_cmp_model (.pin_lvl_i(pin_lvl), .vref_lvl_i(vref_lvl),
        .c1_plus_i(cmp1_plus_sel_o), .c1_minus_i(cmp1_minus_sel_o),
        .c2_plus_i(cmp2_plus_sel_o), .c2_minus_i(cmp2_minus_sel_o), .vref_i(vref_to_plus_o),
        .c1_en_i(cmp1_en_o), .c2_en_i(cmp2_en_o), .cmp1_raw_o(cmp1_raw_i),
        .cmp2_raw_o(cmp2_raw_i));
    // ------------------------------------------------------------
    // Bus, compare and closing tasks
    // ------------------------------------------------------------
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // Classic cycle held until ack; data taken at the ack edge only
    task automatic wb(input logic [7:0] a, input logic w, input logic [3:0] s,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_adr_i <= a;
        wb_we_i  <= w;
        wb_sel_i <= s;
        wb_dat_i <= d;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        if (n >= 50) begin
            miscompares++; // A lost ack counts as a failure
            $display("CHECK FAILED t=%0t no ack", $time);
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        wb(a, 1'b0, 4'hF, 32'h0);
        chk(rd, exp);
    endtask
    // Results cross a two-flop synchroniser, so let them land
    task automatic settle();
        repeat (3) @(posedge clk_i);
    endtask
    task automatic tally_and_finish();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rdc(DCC_OFS_CTRL, 32'h07);
        rdc(DCC_OFS_STATUS, 32'h0);
        wb(DCC_OFS_CTRL, 1'b1, 4'h0, 32'h0);        // Byte lane off: ignored
        rdc(DCC_OFS_CTRL, 32'h07);
        rdc(8'h10, 32'h0);                          // Unmapped reads zero
        chk({cmp1_en_o, cmp2_en_o}, 32'h0);
    endtask
    // Mode 010 with switch both ways, then with both inversions
    task automatic t_vref_switch_inv();
        wb(DCC_OFS_CTRL, 1'b1, 4'hF, 32'h02);
        settle();
        chk({cmp1_minus_sel_o, cmp2_minus_sel_o, vref_to_plus_o}, 32'h03);
        rdc(DCC_OFS_CTRL, 32'hC2);
        wb(DCC_OFS_CTRL, 1'b1, 4'hF, 32'h0A);
        settle();
        chk({cmp1_minus_sel_o, cmp2_minus_sel_o}, 32'h1A);
        rdc(DCC_OFS_CTRL, 32'h0A);
        wb(DCC_OFS_CTRL, 1'b1, 4'hF, 32'h32);
        settle();
        rdc(DCC_OFS_CTRL, 32'h32);
        chk({cmp2_pin_o, cmp1_pin_o}, 32'h0);
        wb(DCC_OFS_CTRL, 1'b1, 4'hF, 32'h3A);
        settle();
        rdc(DCC_OFS_CTRL, 32'hFA);
        chk({cmp2_pin_o, cmp1_pin_o}, 32'h3);
    endtask
    task automatic t_single();
        wb(DCC_OFS_CTRL, 1'b1, 4'hF, 32'h09);
        settle();
        chk({cmp1_minus_sel_o, cmp2_en_o}, 32'h6);
        chk({cmp1_plus_sel_o, cmp2_plus_sel_o}, 32'h17);
        rdc(DCC_OFS_CTRL, 32'h09);                  // Comparator two off reads 0
        wb(DCC_OFS_CTRL, 1'b1, 4'hF, 32'h01);
        settle();
        chk({29'h0, cmp1_minus_sel_o}, 32'h0);
    endtask
    // Interrupts stay masked while the mode walks through all eight values
    task automatic t_modes();
        wb(DCC_OFS_MASK, 1'b1, 4'hF, 32'h0);
        for (int m = 0; m < 8; m++) begin
            wb(DCC_OFS_CTRL, 1'b1, 4'hF, 32'(m));
            settle();
            wb(DCC_OFS_CTRL, 1'b0, 4'hF, 32'h0);
            chk(rd & 32'h1F, 32'(m));
            chk({vref_to_plus_o, pin3_out_en_o, pin4_out_en_o, cmp1_en_o},
                {28'h0, m == 2, m == 5 || m == 6, m == 5 || m == 6, m != 7});
        end
    endtask
    task automatic t_irq();
        wb(DCC_OFS_CTRL, 1'b1, 4'hF, 32'h02);       // Both results high
        settle();
        wb(DCC_OFS_MASK, 1'b1, 4'hF, 32'h1);
        rdc(DCC_OFS_CTRL, 32'hC2);                  // Latch current results
        wb(DCC_OFS_STATUS, 1'b1, 4'hF, 32'h1);
        rdc(DCC_OFS_STATUS, 32'h0);
        vref_lvl <= 8'h05;                          // Both results fall
        settle();
        rdc(DCC_OFS_STATUS, 32'h1);
        chk({31'h0, irq_o}, 32'h1);
        wb(DCC_OFS_MASK, 1'b1, 4'hF, 32'h0);
        settle();
        chk({31'h0, irq_o}, 32'h0);                 // Masked
        wb(DCC_OFS_STATUS, 1'b1, 4'hF, 32'h1);
        settle();
        rdc(DCC_OFS_STATUS, 32'h1);                 // Mismatch still sets
        rdc(DCC_OFS_CTRL, 32'h02);
        wb(DCC_OFS_STATUS, 1'b1, 4'hF, 32'h1);
        settle();
        rdc(DCC_OFS_STATUS, 32'h0);
    endtask
    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_vref_switch_inv();
        t_single();
        t_modes();
        t_irq();
        tally_and_finish();
    end
    // Whole run needs a few hundred cycles; allow far more
    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        tally_and_finish();
    end
endmodule
